//--- astc_cfg.svh
// Register offsets, field positions, reset values and timing counts of the serial core.
`ifndef ASTC_CFG_SVH
`define ASTC_CFG_SVH

// Byte offsets of the 32-bit Wishbone registers.
`define ASTC_OFS_DATA    8'h00
`define ASTC_OFS_STATUS  8'h04
`define ASTC_OFS_CTRL0   8'h08
`define ASTC_OFS_CTRL1   8'h0C
`define ASTC_OFS_BAUD    8'h10
`define ASTC_OFS_TIMER   8'h14

// Status register bit positions.
`define ASTC_ST_RX_AVAIL   0
`define ASTC_ST_PAR_ERR    1
`define ASTC_ST_OVERRUN    2
`define ASTC_ST_FRAME_ERR  3
`define ASTC_ST_BREAK      4
`define ASTC_ST_TX_EMPTY   5
`define ASTC_ST_TX_IDLE    6
`define ASTC_ST_CTS        7
`define ASTC_ST_RX_NINTH   8
`define ASTC_ST_TIMER      9

// Control 0 bit positions.
`define ASTC_C0_TX_EN      0
`define ASTC_C0_RX_EN      1
`define ASTC_C0_PAR_EN     2
`define ASTC_C0_PAR_ODD    3
`define ASTC_C0_STOP2      4
`define ASTC_C0_FLOW_EN    5
`define ASTC_C0_TIMER      6

// Control 1 bit positions.
`define ASTC_C1_NINE_BIT   0
`define ASTC_C1_ADDR_FLAG  1
`define ASTC_C1_SCHEME_LO  2

// Reset values and bit timing.
`define ASTC_RST_DIVISOR   16'h0001
`define ASTC_OVS_LAST      4'hF
`define ASTC_OVS_MID       4'h7
`define ASTC_LAST_BIT      3'h7

`endif

//--- astc_pkg.sv
// Types shared by the serial core: bus carrier, state codes and the state record.
package astc_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } astc_wb_req_t;

  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_START = 5'h02,
    TX_DATA  = 5'h04,
    TX_PAR   = 5'h08,
    TX_STOP  = 5'h10
  } astc_tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_PAR   = 5'h08,
    RX_STOP  = 5'h10
  } astc_rx_state_t;

  typedef struct packed {
    logic [2:0]     rxSync;
    logic [2:0]     ctsSync;
    logic           rxLevel;
    logic           rxPrev;
    logic           ctsLevel;
    logic           txEn;
    logic           rxEn;
    logic           parEn;
    logic           parOdd;
    logic           stop2;
    logic           flowEn;
    logic           timerMode;
    logic           nineBit;
    logic           addrFlag;
    logic [1:0]     rxScheme;
    logic [15:0]    divisor;
    logic [15:0]    baudCnt;
    logic           tick;
    logic           timerFlag;
    astc_tx_state_t txState;
    logic [7:0]     txHold;
    logic           txHoldNinth;
    logic           txHoldFull;
    logic [7:0]     txShift;
    logic           txNinth;
    logic [3:0]     txCnt;
    logic [2:0]     txBit;
    logic           txStopLeft;
    logic           txLine;
    logic           drvEn;
    astc_rx_state_t rxState;
    logic [7:0]     rxShift;
    logic           rxNinth;
    logic [3:0]     rxCnt;
    logic [2:0]     rxBit;
    logic [7:0]     rxData;
    logic           rxDataNinth;
    logic           rxAvail;
    logic           errParity;
    logic           errOverrun;
    logic           errFrame;
    logic           errBreak;
    logic           ack;
    logic [31:0]    rdData;
  } astc_state_t;

endpackage

//--- astc_core.sv
// Asynchronous serial port with Wishbone register access, flow control and 9-bit mode.
`timescale 1ns/1ps
`include "astc_cfg.svh"

module astc_core
  import astc_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire astc_wb_req_t wbReq,
  output logic              wb_ack_o,
  output logic [31:0]       wb_dat_o,
  input  wire logic         serialRxd,
  output logic              serialTxd,
  input  wire logic         clearToSendN,
  output logic              driverEnable,
  output logic              txIrq,
  output logic              rxIrq
);

  astc_state_t r;
  astc_state_t n;

  logic access;
  logic wrAccess;
  logic rdAccess;
  logic txEnd;
  logic rxEnd;
  logic rxBitNow;
  logic rxErrAny;

  // A request is answered one cycle after it is seen; the answer drops the cycle after.
  assign access   = wbReq.cyc && wbReq.stb && !r.ack;
  assign wrAccess = access && wbReq.we;
  assign rdAccess = access && !wbReq.we;
  assign txEnd    = r.tick && (r.txCnt == `ASTC_OVS_LAST);
  assign rxEnd    = r.tick && (r.rxCnt == `ASTC_OVS_LAST);
  assign rxBitNow = r.rxLevel;
  assign rxErrAny = r.errParity | r.errOverrun | r.errFrame | r.errBreak;

  always_comb begin
    n = r;
    n.ack = access;

    // Pins from outside pass three flops; a level counts once the last two agree.
    n.rxSync  = {r.rxSync[1:0], serialRxd};
    n.ctsSync = {r.ctsSync[1:0], clearToSendN};
    if (r.rxSync[1] == r.rxSync[2]) begin
      n.rxLevel = r.rxSync[2];
    end
    if (r.ctsSync[1] == r.ctsSync[2]) begin
      n.ctsLevel = r.ctsSync[2];
    end
    n.rxPrev = r.rxLevel;

    // One free-running divider times both directions and serves as the timer.
    n.tick = 1'b0;
    if (r.baudCnt == 16'h0000) begin
      n.baudCnt = (r.divisor == 16'h0000) ? 16'h0000 : r.divisor - 16'h0001;
      n.tick    = 1'b1;
      if (r.timerMode) begin
        n.timerFlag = 1'b1;
      end
    end else begin
      n.baudCnt = r.baudCnt - 16'h0001;
    end

    // Read data is registered; an unmapped address reads zero.
    if (rdAccess) begin
      n.rdData = 32'h0000_0000;
      if (wbReq.adr == `ASTC_OFS_DATA) begin
        n.rdData[7:0] = r.rxData;
        n.rxAvail     = 1'b0;
        n.errParity   = 1'b0;
        n.errOverrun  = 1'b0;
        n.errFrame    = 1'b0;
        n.errBreak    = 1'b0;
      end else if (wbReq.adr == `ASTC_OFS_STATUS) begin
        n.rdData[`ASTC_ST_RX_AVAIL]  = r.rxAvail;
        n.rdData[`ASTC_ST_PAR_ERR]   = r.errParity;
        n.rdData[`ASTC_ST_OVERRUN]   = r.errOverrun;
        n.rdData[`ASTC_ST_FRAME_ERR] = r.errFrame;
        n.rdData[`ASTC_ST_BREAK]     = r.errBreak;
        n.rdData[`ASTC_ST_TX_EMPTY]  = !r.txHoldFull;
        n.rdData[`ASTC_ST_TX_IDLE]   = (r.txState == TX_IDLE);
        n.rdData[`ASTC_ST_CTS]       = !r.ctsLevel;
        n.rdData[`ASTC_ST_RX_NINTH]  = r.rxDataNinth;
        n.rdData[`ASTC_ST_TIMER]     = r.timerFlag;
        n.timerFlag = 1'b0;
        // A reload in the same cycle as this read sets the flag again, so no event is lost.
        if (r.baudCnt == 16'h0000 && r.timerMode) begin
          n.timerFlag = 1'b1;
        end
      end else if (wbReq.adr == `ASTC_OFS_CTRL0) begin
        n.rdData[`ASTC_C0_TX_EN]   = r.txEn;
        n.rdData[`ASTC_C0_RX_EN]   = r.rxEn;
        n.rdData[`ASTC_C0_PAR_EN]  = r.parEn;
        n.rdData[`ASTC_C0_PAR_ODD] = r.parOdd;
        n.rdData[`ASTC_C0_STOP2]   = r.stop2;
        n.rdData[`ASTC_C0_FLOW_EN] = r.flowEn;
        n.rdData[`ASTC_C0_TIMER]   = r.timerMode;
      end else if (wbReq.adr == `ASTC_OFS_CTRL1) begin
        n.rdData[`ASTC_C1_NINE_BIT]  = r.nineBit;
        n.rdData[`ASTC_C1_ADDR_FLAG] = r.addrFlag;
        n.rdData[`ASTC_C1_SCHEME_LO +: 2] = r.rxScheme;
      end else if (wbReq.adr == `ASTC_OFS_BAUD) begin
        n.rdData[15:0] = r.divisor;
      end else if (wbReq.adr == `ASTC_OFS_TIMER) begin
        n.rdData[15:0] = r.baudCnt;
      end
    end

    // Register writes honour byte lanes; a data write while full is dropped.
    if (wrAccess) begin
      if (wbReq.adr == `ASTC_OFS_DATA && wbReq.sel[0]) begin
        if (!r.txHoldFull) begin
          n.txHold      = wbReq.dat[7:0];
          n.txHoldNinth = r.addrFlag;
          n.txHoldFull  = 1'b1;
        end
      end else if (wbReq.adr == `ASTC_OFS_CTRL0 && wbReq.sel[0]) begin
        n.txEn      = wbReq.dat[`ASTC_C0_TX_EN];
        n.rxEn      = wbReq.dat[`ASTC_C0_RX_EN];
        n.parEn     = wbReq.dat[`ASTC_C0_PAR_EN];
        n.parOdd    = wbReq.dat[`ASTC_C0_PAR_ODD];
        n.stop2     = wbReq.dat[`ASTC_C0_STOP2];
        n.flowEn    = wbReq.dat[`ASTC_C0_FLOW_EN];
        n.timerMode = wbReq.dat[`ASTC_C0_TIMER];
      end else if (wbReq.adr == `ASTC_OFS_CTRL1 && wbReq.sel[0]) begin
        n.nineBit  = wbReq.dat[`ASTC_C1_NINE_BIT];
        n.addrFlag = wbReq.dat[`ASTC_C1_ADDR_FLAG];
        n.rxScheme = wbReq.dat[`ASTC_C1_SCHEME_LO +: 2];
      end else if (wbReq.adr == `ASTC_OFS_BAUD) begin
        if (wbReq.sel[0]) begin
          n.divisor[7:0] = wbReq.dat[7:0];
        end
        if (wbReq.sel[1]) begin
          n.divisor[15:8] = wbReq.dat[15:8];
        end
      end
    end

    // Transmitter: counts 16 ticks per bit and never stops mid-character.
    if (r.tick && r.txState != TX_IDLE) begin
      n.txCnt = r.txCnt + 4'h1;
    end
    case (r.txState)
      TX_IDLE: begin
        n.txLine = 1'b1;
        // Clear-to-send is looked at in the cycle before the start bit.
        if (r.txEn && r.txHoldFull && (!r.flowEn || !r.ctsLevel)) begin
          n.txShift    = r.txHold;
          n.txNinth    = r.nineBit ? r.txHoldNinth : (^r.txHold ^ r.parOdd);
          n.txHoldFull = 1'b0;
          n.txLine     = 1'b0;
          n.txCnt      = 4'h0;
          n.txState    = TX_START;
        end
      end
      TX_START: begin
        if (txEnd) begin
          n.txLine  = r.txShift[0];
          n.txBit   = 3'h0;
          n.txState = TX_DATA;
        end
      end
      TX_DATA: begin
        if (txEnd) begin
          n.txShift = {1'b0, r.txShift[7:1]};
          n.txBit   = r.txBit + 3'h1;
          n.txLine  = r.txShift[1];
          if (r.txBit == `ASTC_LAST_BIT) begin
            if (r.nineBit || r.parEn) begin
              n.txLine  = r.txNinth;
              n.txState = TX_PAR;
            end else begin
              n.txLine     = 1'b1;
              n.txStopLeft = r.stop2;
              n.txState    = TX_STOP;
            end
          end
        end
      end
      TX_PAR: begin
        if (txEnd) begin
          n.txLine     = 1'b1;
          n.txStopLeft = r.stop2;
          n.txState    = TX_STOP;
        end
      end
      TX_STOP: begin
        if (txEnd) begin
          n.txStopLeft = 1'b0;
          if (!r.txStopLeft) begin
            n.txState = TX_IDLE;
          end
        end
      end
      default: begin
        n.txState = TX_IDLE;
      end
    endcase
    n.drvEn = (n.txState != TX_IDLE);

    // Receiver: start edge, check at mid start bit, then sample every 16 ticks.
    if (r.tick && r.rxState != RX_IDLE) begin
      n.rxCnt = r.rxCnt + 4'h1;
    end
    case (r.rxState)
      RX_IDLE: begin
        if (r.rxEn && r.rxPrev && !r.rxLevel) begin
          n.rxCnt   = 4'h0;
          n.rxState = RX_START;
        end
      end
      RX_START: begin
        if (r.tick && r.rxCnt == `ASTC_OVS_MID) begin
          n.rxCnt   = 4'h0;
          n.rxBit   = 3'h0;
          n.rxState = rxBitNow ? RX_IDLE : RX_DATA; // A high here was a glitch.
        end
      end
      RX_DATA: begin
        if (rxEnd) begin
          n.rxShift = {rxBitNow, r.rxShift[7:1]};
          n.rxBit   = r.rxBit + 3'h1;
          if (r.rxBit == `ASTC_LAST_BIT) begin
            n.rxNinth = 1'b0;
            n.rxState = (r.nineBit || r.parEn) ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (rxEnd) begin
          n.rxNinth = rxBitNow;
          n.rxState = RX_STOP;
        end
      end
      RX_STOP: begin
        // Only the first stop bit is checked, so two-stop senders are accepted too.
        if (rxEnd) begin
          n.rxState     = RX_IDLE;
          n.rxData      = r.rxShift;
          n.rxDataNinth = r.rxNinth;
          n.rxAvail     = 1'b1;
          if (r.rxAvail) begin
            n.errOverrun = 1'b1;
          end
          if (!rxBitNow) begin
            n.errFrame = 1'b1;
          end
          if (!rxBitNow && r.rxShift == 8'h00 && !r.rxNinth) begin
            n.errBreak = 1'b1;
          end
          if (r.parEn && !r.nineBit && (r.rxNinth != (^r.rxShift ^ r.parOdd))) begin
            n.errParity = 1'b1;
          end
        end
      end
      default: begin
        n.rxState = RX_IDLE;
      end
    endcase
  end

  // The whole state record is one register bank with asynchronous reset.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r             <= '0;
      r.rxSync      <= 3'h7;
      r.ctsSync     <= 3'h7;
      r.rxLevel     <= 1'b1;
      r.rxPrev      <= 1'b1;
      r.ctsLevel    <= 1'b1;
      r.divisor     <= `ASTC_RST_DIVISOR;
      r.txState     <= TX_IDLE;
      r.rxState     <= RX_IDLE;
      r.txLine      <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Requests are levels; 9-bit mode may narrow which bytes raise the receive request.
  always_comb begin
    txIrq = r.txEn && !r.txHoldFull;
    rxIrq = r.rxAvail || rxErrAny;
    if (r.nineBit) begin
      case (r.rxScheme)
        2'h1: rxIrq = (r.rxAvail && r.rxDataNinth) || rxErrAny;
        2'h2: rxIrq = rxErrAny;
        default: rxIrq = r.rxAvail || rxErrAny;
      endcase
    end
  end

  assign wb_ack_o     = r.ack;
  assign wb_dat_o     = r.rdData;
  assign serialTxd    = r.txLine;
  assign driverEnable = r.drvEn;

endmodule

//--- astc_core_sva.sv
// Port-level assertions for the serial core, bound into every core instance.
`timescale 1ns/1ps
module astc_core_sva
  import astc_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         sys_rst,
  input wire astc_wb_req_t wbReq,
  input wire logic         wb_ack_o,
  input wire logic [31:0]  wb_dat_o,
  input wire logic         serialTxd,
  input wire logic         driverEnable
);
  // One clock domain, so clock and reset are given once here.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // The bus answers one cycle after a fresh request, for one cycle only.
  a_ack_next_cycle: assert property (wbReq.cyc && wbReq.stb && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after a request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");
  // Read data stays put after the ack, and the unmapped place 8'h18 reads zero.
  a_dat_holds: assert property (wb_ack_o |=> $stable(wb_dat_o))
    else $error("read data changed after the ack");
  a_unmapped_zero: assert property (wbReq.cyc && wbReq.stb && !wbReq.we && !wb_ack_o
    && wbReq.adr == 8'h18 |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read returned data");
  // The line rests high whenever no character is on its way.
  a_idle_line_high: assert property (!driverEnable |-> serialTxd)
    else $error("line low while the driver is off");
  // A character opens low and closes high; the start bit spans many clocks.
  a_start_bit_low: assert property ($rose(driverEnable) |-> !serialTxd [*8])
    else $error("start bit not low");
  a_stop_bit_high: assert property ($fell(driverEnable) |-> $past(serialTxd))
    else $error("last stop bit not high");
  // A started character is never cut short, whatever clear-to-send does.
  a_frame_whole: assert property ($rose(driverEnable) |->
    driverEnable [*8] ##1 driverEnable [*8])
    else $error("character cut short");
endmodule

bind astc_core astc_core_sva chk (
  .sys_clk     (sys_clk),
  .sys_rst     (sys_rst),
  .wbReq       (wbReq),
  .wb_ack_o    (wb_ack_o),
  .wb_dat_o    (wb_dat_o),
  .serialTxd   (serialTxd),
  .driverEnable(driverEnable)
);

//--- astc_node_model.sv
// Remote serial node: sends characters to the core and collects what it sends.
`timescale 1ns/1ps
module astc_node_model (
  input  wire logic sys_clk,
  input  wire logic serialTxd,
  input  wire logic ninthOn,
  input  wire logic holdOff,
  output logic      serialRxd,
  output logic      clearToSendN
);
  // Divisor one gives sixteen clocks per bit.
  localparam int BIT_CYC = 16;
  logic [9:0] got;
  logic [9:0] rxQ[$];

  // Clear-to-send is active low; holding off raises it.
  assign clearToSendN = holdOff;
  initial serialRxd = 1'b1;

  // Start low, data LSB first, optional ninth, then the stop level.
  task automatic send_frame(input logic [7:0] val, input logic ninth,
                            input logic useNinth, input logic stopLvl);
    logic [10:0] bits;
    bits = {stopLvl, useNinth ? ninth : stopLvl, val, 1'b0};
    for (int i = 0; i < (useNinth ? 11 : 10); i++) begin
      serialRxd <= bits[i];
      repeat (BIT_CYC) @(posedge sys_clk);
    end
    serialRxd <= 1'b1;
  endtask

  // Receiver samples mid-bit and queues {stop, ninth, data}.
  always begin
    @(negedge serialTxd);
    repeat (BIT_CYC / 2) @(posedge sys_clk);
    for (int i = 0; i < (ninthOn ? 10 : 9); i++) begin
      repeat (BIT_CYC) @(posedge sys_clk);
      got[i] = serialTxd;
    end
    rxQ.push_back(ninthOn ? got : {got[8], 1'b0, got[7:0]});
  end
endmodule

//--- astc_core_tb.sv
// Self-checking bench for the serial core with a remote node on its line.
`timescale 1ns/1ps
`include "astc_cfg.svh"
module astc_core_tb
  import astc_pkg::*;
;
  logic         sys_clk;
  logic         sys_rst;
  astc_wb_req_t wbReq;
  logic         wb_ack_o;
  logic [31:0]  wb_dat_o;
  logic         serialRxd;
  logic         serialTxd;
  logic         clearToSendN;
  logic         driverEnable;
  logic         txIrq;
  logic         rxIrq;
  logic         ninthOn;
  logic         holdOff;
  int           miscompares = 0;
  int           checked = 0;
  int           deRun = 0;
  int           deLen = 0;

  astc_core dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .wbReq(wbReq), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .serialRxd(serialRxd), .serialTxd(serialTxd),
    .clearToSendN(clearToSendN), .driverEnable(driverEnable), .txIrq(txIrq), .rxIrq(rxIrq));
  astc_node_model node (.sys_clk(sys_clk), .serialTxd(serialTxd), .ninthOn(ninthOn),
    .holdOff(holdOff), .serialRxd(serialRxd), .clearToSendN(clearToSendN));

  // 200 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Measures how long the driver enable stays up for each burst.
  always @(posedge sys_clk) begin
    if (driverEnable === 1'b1) deRun <= deRun + 1;
    else if (deRun != 0) begin
      deLen <= deRun;
      deRun <= 0;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; waits for ack, bounded so a dead bus cannot hang us.
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                          output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge sys_clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    if (n >= 50) check(32'h0000_0000, 32'h0000_0001);
    wbReq <= '0;
  endtask

  task automatic wb_write(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] rd;
    wb_cycle(1'b1, adr, dat, rd);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    wb_cycle(1'b0, adr, 32'h0, rd);
    check(rd, exp);
  endtask

  // Settles a received character, checks masked status, then drains the data.
  task automatic status_chk(input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] rd;
    repeat (8) @(posedge sys_clk);
    wb_cycle(1'b0, `ASTC_OFS_STATUS, 32'h0, rd);
    check(rd & mask, exp);
    wb_cycle(1'b0, `ASTC_OFS_DATA, 32'h0, rd);
  endtask

  // Polled send: wait for an empty holding register, then write the byte.
  task automatic send_tx(input logic [7:0] val);
    logic [31:0] rd;
    int n;
    n = 0;
    do begin
      wb_cycle(1'b0, `ASTC_OFS_STATUS, 32'h0, rd);
      n++;
    end while (rd[`ASTC_ST_TX_EMPTY] !== 1'b1 && n < 500);
    if (n >= 500) check(32'h0000_0000, 32'h0000_0001);
    wb_write(`ASTC_OFS_DATA, {24'h0, val});
  endtask

  // Pops the next character seen by the node; len 0 skips the width check.
  task automatic expect_frame(input logic [9:0] exp, input int len);
    logic [9:0] got;
    int n;
    n = 0;
    while (node.rxQ.size() == 0 && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    got = (node.rxQ.size() != 0) ? node.rxQ.pop_front() : 'x;
    check({22'h0, got}, {22'h0, exp});
    repeat (40) @(posedge sys_clk);
    if (len != 0) check(deLen, len);
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Cuts a hang short; the whole run needs well under this span.
  initial begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    stop_test;
  end

  initial begin
    wbReq = '0;
    sys_rst = 1'b1;
    ninthOn = 1'b0;
    holdOff = 1'b0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // The clear-to-send level needs a few clocks through its synchroniser first.
    repeat (4) @(posedge sys_clk);
    // Reset state, and an unmapped place that ignores writes.
    rd_chk(`ASTC_OFS_STATUS, 32'h0000_00E0);
    rd_chk(`ASTC_OFS_BAUD, 32'h0000_0001);
    wb_write(8'h18, 32'hFFFF_FFFF);
    rd_chk(8'h18, 32'h0000_0000);
    check({31'h0, txIrq}, 32'h0000_0000);
    wb_write(`ASTC_OFS_CTRL0, 32'h0000_0003);
    repeat (2) @(posedge sys_clk);
    check({31'h0, txIrq}, 32'h0000_0001);
    // Two bytes back to back while one arrives the other way.
    fork
      begin
        send_tx(8'hA5);
        send_tx(8'h3C);
      end
      node.send_frame(8'hC3, 1'b0, 1'b0, 1'b1);
    join
    expect_frame(10'h2A5, 0);
    expect_frame(10'h23C, 0);
    check({31'h0, rxIrq}, 32'h0000_0001);
    rd_chk(`ASTC_OFS_DATA, 32'h0000_00C3);
    // Parity with both senses and both stop counts.
    ninthOn = 1'b1;
    for (int k = 0; k < 4; k++) begin
      wb_write(`ASTC_OFS_CTRL0, 32'h0000_0007 | (k << 3));
      send_tx(8'h5B);
      expect_frame({1'b1, ~k[0], 8'h5B}, 176 + 16 * k[1]);
    end
    node.send_frame(8'h5B, 1'b0, 1'b1, 1'b1);
    status_chk(32'h0000_001F, 32'h0000_0001);
    node.send_frame(8'h5B, 1'b1, 1'b1, 1'b1);
    status_chk(32'h0000_001E, 32'h0000_0002);
    // Framing, break, overrun, then a disabled receiver.
    ninthOn = 1'b0;
    wb_write(`ASTC_OFS_CTRL0, 32'h0000_0003);
    node.send_frame(8'h0F, 1'b0, 1'b0, 1'b0);
    status_chk(32'h0000_001E, 32'h0000_0008);
    node.send_frame(8'h00, 1'b0, 1'b0, 1'b0);
    status_chk(32'h0000_001E, 32'h0000_0018);
    node.send_frame(8'h11, 1'b0, 1'b0, 1'b1);
    node.send_frame(8'h22, 1'b0, 1'b0, 1'b1);
    status_chk(32'h0000_001E, 32'h0000_0004);
    wb_write(`ASTC_OFS_CTRL0, 32'h0000_0001);
    node.send_frame(8'h33, 1'b0, 1'b0, 1'b1);
    status_chk(32'h0000_0001, 32'h0000_0000);
    // The address flag is fixed per byte when it is queued.
    ninthOn = 1'b1;
    wb_write(`ASTC_OFS_CTRL1, 32'h0000_0003);
    send_tx(8'h81);
    send_tx(8'h42);
    wb_write(`ASTC_OFS_CTRL1, 32'h0000_0001);
    send_tx(8'h17);
    expect_frame(10'h381, 0);
    expect_frame(10'h342, 0);
    expect_frame(10'h217, 0);
    // Clear-to-send withdrawn mid character holds only the next one.
    ninthOn = 1'b0;
    wb_write(`ASTC_OFS_CTRL1, 32'h0000_0000);
    wb_write(`ASTC_OFS_CTRL0, 32'h0000_0021);
    send_tx(8'h66);
    holdOff <= 1'b1;
    send_tx(8'h77);
    expect_frame(10'h266, 0);
    repeat (200) @(posedge sys_clk);
    check({31'h0, driverEnable}, 32'h0000_0000);
    status_chk(32'h0000_00E0, 32'h0000_0040);
    holdOff <= 1'b0;
    expect_frame(10'h277, 0);
    // Receive request schemes of 9-bit mode: address bytes only, then errors only.
    wb_write(`ASTC_OFS_CTRL0, 32'h0000_0002);
    wb_write(`ASTC_OFS_CTRL1, 32'h0000_0005);
    node.send_frame(8'h24, 1'b0, 1'b1, 1'b1);
    repeat (8) @(posedge sys_clk);
    check({31'h0, rxIrq}, 32'h0000_0000);
    status_chk(32'h0000_0101, 32'h0000_0001);
    node.send_frame(8'h24, 1'b1, 1'b1, 1'b1);
    repeat (8) @(posedge sys_clk);
    check({31'h0, rxIrq}, 32'h0000_0001);
    status_chk(32'h0000_0101, 32'h0000_0101);
    wb_write(`ASTC_OFS_CTRL1, 32'h0000_0009);
    node.send_frame(8'h24, 1'b1, 1'b1, 1'b1);
    repeat (8) @(posedge sys_clk);
    check({31'h0, rxIrq}, 32'h0000_0000);
    status_chk(32'h0000_0001, 32'h0000_0001);
    // Baud generator as a plain timer.
    wb_write(`ASTC_OFS_BAUD, 32'h0000_0010);
    wb_write(`ASTC_OFS_CTRL0, 32'h0000_0040);
    repeat (40) @(posedge sys_clk);
    status_chk(32'h0000_0200, 32'h0000_0200);
    stop_test;
  end
endmodule
